// [rtl/ccp_pkg.sv]
// shared types and constants for the control and pointer instruction core
package ccp_pkg;

  // ---------------------------------------------------------------
  // widths and field positions
  // ---------------------------------------------------------------
  localparam int INSTR_W   = 14;
  localparam int PC_W      = 15;
  localparam int PTR_W     = 16;
  localparam int REL_K_W   = 9;
  localparam int ABS_K_W   = 11;
  localparam int IDX_K_W   = 6;
  localparam int LIT_W     = 8;
  localparam int FILE_W    = 7;
  localparam int DEST_POS  = 7;
  localparam int SEL_IDX_POS = 6;
  localparam int SEL_MODE_POS = 2;
  localparam int DIR_SEL_W = 3;
  localparam int DIR_REGS  = 8;

  // ---------------------------------------------------------------
  // reset values, counts and special addresses
  // ---------------------------------------------------------------
  localparam logic [PC_W-1:0]  PC_RST    = 15'h0000;
  localparam logic [PC_W-1:0]  PC_STEP   = 15'h0001;
  localparam logic [7:0]       ACC_RST   = 8'h00;
  localparam logic [7:0]       PRESC_RST = 8'hFF;
  localparam logic [7:0]       DIR_RST   = 8'hFF;
  localparam logic [PTR_W-1:0] PTR_RST   = 16'h0000;
  localparam logic [PTR_W-1:0] PTR_STEP  = 16'h0001;
  localparam logic [2:0]       CYC_CLKS  = 3'h2;
  localparam logic [FILE_W-1:0] PORT0_ADDR = 7'h00;
  localparam logic [FILE_W-1:0] PORT1_ADDR = 7'h01;

  // pointer update modes
  localparam logic [1:0] MODE_PRE_INC  = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum {
    OP_IDLE, OP_REL_JUMP, OP_REL_JUMP_ACC, OP_SUB_ENTER, OP_SUB_ENTER_ACC,
    OP_ABS_JUMP, OP_IRQ_EXIT, OP_SUB_EXIT, OP_SUB_EXIT_LIT, OP_STANDBY,
    OP_DOG_KICK, OP_LOAD_PRESC, OP_SOFT_RESTART, OP_LOAD_DIR, OP_PTR_ADD,
    OP_PTR_LOAD, OP_PTR_STORE, OP_IDX_LOAD, OP_IDX_STORE, OP_AND_LIT,
    OP_ADD_LIT, OP_AND_FILE
  } ccp_op_t;

  typedef struct packed {
    logic watchdog_expiry_bit;
    logic powerdown_bit;
    logic z;
    logic nibble_out_bit;
    logic c;
  } ccp_status_t;

  localparam ccp_status_t STATUS_RST = 5'h18;

  typedef struct packed {
    logic [PTR_W-1:0] addr;
    logic             rd;
    logic             wr;
    logic [7:0]       wdata;
  } ccp_mem_req_t;

endpackage

// [rtl/ccp_ret_stack.sv]
// return address stack for subroutine entry and exit
`timescale 1ns/100ps
`default_nettype none
module ccp_ret_stack #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 15
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             push_i,
  input  wire logic             pop_i,
  input  wire logic [WIDTH-1:0] data_i,
  output logic      [WIDTH-1:0] top_o
);

  localparam int SP_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [SP_W-1:0]  sp_q;
  logic [SP_W-1:0]  sp_top;

  // pointer wraps around on overflow and underflow
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sp_q <= '0;
    end else if (push_i) begin
      sp_q <= sp_q + SP_W'(1);
    end else if (pop_i) begin
      sp_q <= sp_q - SP_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (push_i) begin
      mem_q[sp_q] <= data_i;
    end
  end

  assign sp_top = sp_q - SP_W'(1);
  assign top_o  = mem_q[sp_top];

endmodule
`default_nettype wire

// [rtl/ccp_core.sv]
// instruction core: control flow, inherent, pointer and and/add operations
//
// Functional notes
// - pc-changing instructions take two instruction cycles, second one idle.
// - indirect access with pointer msb set adds one instruction cycle.
// - decode relative jump and accumulator relative jump; two cycles, no flags.
// - decode subroutine entry, accumulator entry and absolute jump; two cycles.
// - decode interrupt exit, subroutine exit and literal exit; two cycles.
// - standby and watchdog kick are single cycle and update expiry/powerdown bits.
// - prescaler load, soft restart and idle op: single cycle, no flags.
// - direction load copies accumulator into register chosen by low three bits; values 2 to 4 decode as prescaler load, standby and watchdog kick.
// - pointer add sign-extends 6-bit literal onto pointer pair, no flags.
// - pointer arithmetic wraps modulo 65536.
// - indirect load with pointer update mode sets zero flag.
// - indirect store with pointer update mode leaves flags alone.
// - indexed load reads pointer plus 6-bit index, sets zero flag.
// - indexed store writes pointer plus 6-bit index, no flags.
// - and literal into accumulator, zero flag only.
// - add literal into accumulator, updates carry, nibble carry, zero.
// - and with file register, destination bit picks accumulator or file.
// - relative jump offset is a signed 9-bit low field.
// - entry and absolute jump carry an 11-bit low target field.
// - update forms carry one-bit pointer select and 2-bit mode.
`timescale 1ns/100ps
`default_nettype none
module ccp_core #(
  parameter int STACK_DEPTH = 16
) (
  input  wire logic                         ref_clk_i,
  input  wire logic                         nrst_i,
  input  wire logic                         instr_valid_i,
  input  wire logic [ccp_pkg::INSTR_W-1:0]  instr_i,
  output logic                              instr_ready_o,
  output logic      [ccp_pkg::PC_W-1:0]     pc_o,
  output var ccp_pkg::ccp_mem_req_t         mem_req_o,
  input  wire logic [7:0]                   mem_rdata_i,
  output logic      [7:0]                   acc_o,
  output var ccp_pkg::ccp_status_t          status_o,
  output logic      [ccp_pkg::PTR_W-1:0]    ptr0_o,
  output logic      [ccp_pkg::PTR_W-1:0]    ptr1_o,
  output logic      [7:0]                   presc_cfg_o,
  output logic      [ccp_pkg::DIR_REGS-1:0][7:0] dir_reg_o,
  output logic                              standby_o,
  output logic                              dog_kick_o,
  output logic                              soft_restart_o,
  output logic                              irq_exit_o
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic ccp_pkg::ccp_op_t decode(input logic [13:0] ins);
    ccp_pkg::ccp_op_t op;
    op = ccp_pkg::OP_IDLE;
    casez (ins)
      14'b11_001?_????_????: op = ccp_pkg::OP_REL_JUMP;
      14'b00_0000_0000_1011: op = ccp_pkg::OP_REL_JUMP_ACC;
      14'b10_0???_????_????: op = ccp_pkg::OP_SUB_ENTER;
      14'b00_0000_0000_1010: op = ccp_pkg::OP_SUB_ENTER_ACC;
      14'b10_1???_????_????: op = ccp_pkg::OP_ABS_JUMP;
      14'b00_0000_0000_1001: op = ccp_pkg::OP_IRQ_EXIT;
      14'b00_0000_0000_1000: op = ccp_pkg::OP_SUB_EXIT;
      14'b11_0100_????_????: op = ccp_pkg::OP_SUB_EXIT_LIT;
      14'b00_0000_0110_0011: op = ccp_pkg::OP_STANDBY;
      14'b00_0000_0110_0100: op = ccp_pkg::OP_DOG_KICK;
      14'b00_0000_0110_0010: op = ccp_pkg::OP_LOAD_PRESC;
      14'b00_0000_0000_0001: op = ccp_pkg::OP_SOFT_RESTART;
      14'b00_0000_0000_0000: op = ccp_pkg::OP_IDLE;
      14'b00_0000_0110_0???: op = ccp_pkg::OP_LOAD_DIR;
      14'b11_0001_0???_????: op = ccp_pkg::OP_PTR_ADD;
      14'b00_0000_0001_0???: op = ccp_pkg::OP_PTR_LOAD;
      14'b00_0000_0001_1???: op = ccp_pkg::OP_PTR_STORE;
      14'b11_1111_0???_????: op = ccp_pkg::OP_IDX_LOAD;
      14'b11_1111_1???_????: op = ccp_pkg::OP_IDX_STORE;
      14'b11_1001_????_????: op = ccp_pkg::OP_AND_LIT;
      14'b11_1110_????_????: op = ccp_pkg::OP_ADD_LIT;
      14'b00_0101_????_????: op = ccp_pkg::OP_AND_FILE;
      default:               op = ccp_pkg::OP_IDLE;
    endcase
    return op;
  endfunction

  // pointer select bit sits at a different place per form
  function automatic logic ptr_sel(input ccp_pkg::ccp_op_t op, input logic [13:0] ins);
    logic sel;
    sel = ins[ccp_pkg::SEL_IDX_POS];
    if (op == ccp_pkg::OP_PTR_LOAD || op == ccp_pkg::OP_PTR_STORE) begin
      sel = ins[ccp_pkg::SEL_MODE_POS];
    end
    return sel;
  endfunction

  function automatic logic [ccp_pkg::PTR_W-1:0] sext_idx(input logic [13:0] ins);
    return {{(ccp_pkg::PTR_W-ccp_pkg::IDX_K_W){ins[ccp_pkg::IDX_K_W-1]}},
            ins[ccp_pkg::IDX_K_W-1:0]};
  endfunction

  function automatic logic two_cycle(input ccp_pkg::ccp_op_t op);
    logic t;
    unique case (op)
      ccp_pkg::OP_REL_JUMP, ccp_pkg::OP_REL_JUMP_ACC, ccp_pkg::OP_SUB_ENTER,
      ccp_pkg::OP_SUB_ENTER_ACC, ccp_pkg::OP_ABS_JUMP, ccp_pkg::OP_IRQ_EXIT,
      ccp_pkg::OP_SUB_EXIT, ccp_pkg::OP_SUB_EXIT_LIT: t = 1'b1;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // state and storage
  // ---------------------------------------------------------------
  typedef enum {ST_FETCH, ST_EXEC, ST_STALL} ccp_state_t;

  ccp_state_t                  state_q;
  logic [2:0]                  stall_q;
  ccp_pkg::ccp_op_t            op_q;
  logic [13:0]                 ir_q;
  logic                        extra_q;
  logic [ccp_pkg::PC_W-1:0]    pc_q;
  logic [7:0]                  acc_q;
  ccp_pkg::ccp_status_t        status_q;
  logic [ccp_pkg::PTR_W-1:0]   ptr0_q;
  logic [ccp_pkg::PTR_W-1:0]   ptr1_q;
  logic [7:0]                  presc_q;
  logic [ccp_pkg::DIR_REGS-1:0][7:0] dir_q;
  ccp_pkg::ccp_mem_req_t       mem_q;
  logic                        standby_q;
  logic                        dog_kick_q;
  logic                        soft_restart_q;
  logic                        irq_exit_q;

  logic take;
  logic exec;
  assign take = (state_q == ST_FETCH) && instr_valid_i;
  assign exec = (state_q == ST_EXEC);

  // ---------------------------------------------------------------
  // fetch side address and pointer update
  // ---------------------------------------------------------------
  ccp_pkg::ccp_op_t            op_f;
  logic                        sel_f;
  logic [ccp_pkg::PTR_W-1:0]   ptr_cur_f;
  logic [ccp_pkg::PTR_W-1:0]   ptr_upd_f;
  logic [ccp_pkg::PTR_W-1:0]   ea_f;
  logic [ccp_pkg::FILE_W-1:0]  faddr_f;
  logic                        extra_f;

  always_comb begin
    op_f      = decode(instr_i);
    sel_f     = ptr_sel(op_f, instr_i);
    ptr_cur_f = sel_f ? ptr1_q : ptr0_q;
    ptr_upd_f = ptr_cur_f;
    ea_f      = ptr_cur_f;
    faddr_f   = instr_i[ccp_pkg::FILE_W-1:0];
    extra_f   = 1'b0;
    case (op_f)
      ccp_pkg::OP_PTR_ADD: begin
        ptr_upd_f = ptr_cur_f + sext_idx(instr_i);
      end
      ccp_pkg::OP_PTR_LOAD, ccp_pkg::OP_PTR_STORE: begin
        unique case (instr_i[1:0])
          ccp_pkg::MODE_PRE_INC: begin
            ptr_upd_f = ptr_cur_f + ccp_pkg::PTR_STEP;
            ea_f      = ptr_upd_f;
          end
          ccp_pkg::MODE_PRE_DEC: begin
            ptr_upd_f = ptr_cur_f - ccp_pkg::PTR_STEP;
            ea_f      = ptr_upd_f;
          end
          ccp_pkg::MODE_POST_INC: begin
            ptr_upd_f = ptr_cur_f + ccp_pkg::PTR_STEP;
          end
          ccp_pkg::MODE_POST_DEC: begin
            ptr_upd_f = ptr_cur_f - ccp_pkg::PTR_STEP;
          end
        endcase
        extra_f = ptr_cur_f[ccp_pkg::PTR_W-1];
      end
      ccp_pkg::OP_IDX_LOAD, ccp_pkg::OP_IDX_STORE: begin
        ea_f    = ptr_cur_f + sext_idx(instr_i);
        extra_f = ptr_cur_f[ccp_pkg::PTR_W-1];
      end
      ccp_pkg::OP_AND_FILE: begin
        if (faddr_f == ccp_pkg::PORT0_ADDR) begin
          ea_f    = ptr0_q;
          extra_f = ptr0_q[ccp_pkg::PTR_W-1];
        end else if (faddr_f == ccp_pkg::PORT1_ADDR) begin
          ea_f    = ptr1_q;
          extra_f = ptr1_q[ccp_pkg::PTR_W-1];
        end else begin
          ea_f = {{(ccp_pkg::PTR_W-ccp_pkg::FILE_W){1'b0}}, faddr_f};
        end
      end
      default: ;
    endcase
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  logic [2:0] stall_cyc;
  logic [2:0] stall_clks;
  assign stall_cyc  = {2'b00, two_cycle(op_q)} + {2'b00, extra_q};
  assign stall_clks = 3'(stall_cyc * ccp_pkg::CYC_CLKS);

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_FETCH;
      stall_q <= 3'h0;
    end else begin
      unique case (state_q)
        ST_FETCH: begin
          if (instr_valid_i) begin
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          // idle cycle after a pc change, plus one for a high pointer
          if (stall_clks != 3'h0) begin
            state_q <= ST_STALL;
            stall_q <= stall_clks - 3'h1;
          end else begin
            state_q <= ST_FETCH;
          end
        end
        ST_STALL: begin
          if (stall_q == 3'h0) begin
            state_q <= ST_FETCH;
          end else begin
            stall_q <= stall_q - 3'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      op_q    <= ccp_pkg::OP_IDLE;
      ir_q    <= 14'h0000;
      extra_q <= 1'b0;
    end else if (take) begin
      op_q    <= op_f;
      ir_q    <= instr_i;
      extra_q <= extra_f;
    end
  end

  // ---------------------------------------------------------------
  // pointer pairs
  // ---------------------------------------------------------------
  logic ptr_wr;
  assign ptr_wr = take && (op_f == ccp_pkg::OP_PTR_ADD || op_f == ccp_pkg::OP_PTR_LOAD ||
                           op_f == ccp_pkg::OP_PTR_STORE);

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ptr0_q <= ccp_pkg::PTR_RST;
      ptr1_q <= ccp_pkg::PTR_RST;
    end else if (ptr_wr) begin
      if (sel_f) begin
        ptr1_q <= ptr_upd_f;
      end else begin
        ptr0_q <= ptr_upd_f;
      end
    end
  end

  // ---------------------------------------------------------------
  // data memory requests
  // ---------------------------------------------------------------
  logic [7:0] and_res;
  logic       and_src_lit;
  assign and_src_lit = (op_q == ccp_pkg::OP_AND_LIT);
  assign and_res     = acc_q & (and_src_lit ? ir_q[7:0] : mem_rdata_i);

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mem_q <= '0;
    end else begin
      mem_q.rd <= 1'b0;
      mem_q.wr <= 1'b0;
      if (take) begin
        mem_q.addr <= ea_f;
        unique case (op_f)
          ccp_pkg::OP_PTR_LOAD, ccp_pkg::OP_IDX_LOAD, ccp_pkg::OP_AND_FILE: begin
            mem_q.rd <= 1'b1;
          end
          ccp_pkg::OP_PTR_STORE, ccp_pkg::OP_IDX_STORE: begin
            mem_q.wr    <= 1'b1;
            mem_q.wdata <= acc_q;
          end
          default: ;
        endcase
      end else if (exec && op_q == ccp_pkg::OP_AND_FILE && ir_q[ccp_pkg::DEST_POS]) begin
        mem_q.wr    <= 1'b1;
        mem_q.wdata <= and_res;
      end
    end
  end

  // ---------------------------------------------------------------
  // program counter and return stack
  // ---------------------------------------------------------------
  logic                     stk_push;
  logic                     stk_pop;
  logic [ccp_pkg::PC_W-1:0] stk_top;
  logic [ccp_pkg::PC_W-1:0] rel_off;

  assign stk_push = exec && (op_q == ccp_pkg::OP_SUB_ENTER || op_q == ccp_pkg::OP_SUB_ENTER_ACC);
  assign stk_pop  = exec && (op_q == ccp_pkg::OP_IRQ_EXIT || op_q == ccp_pkg::OP_SUB_EXIT ||
                             op_q == ccp_pkg::OP_SUB_EXIT_LIT);
  assign rel_off  = {{(ccp_pkg::PC_W-ccp_pkg::REL_K_W){ir_q[ccp_pkg::REL_K_W-1]}},
                     ir_q[ccp_pkg::REL_K_W-1:0]};

  ccp_ret_stack #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (ccp_pkg::PC_W)
  ) u_stack (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_q),
    .push_i    (stk_push),
    .pop_i     (stk_pop),
    .data_i    (pc_q),
    .top_o     (stk_top)
  );

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pc_q <= ccp_pkg::PC_RST;
    end else if (take) begin
      pc_q <= pc_q + ccp_pkg::PC_STEP;
    end else if (exec) begin
      case (op_q)
        ccp_pkg::OP_REL_JUMP: begin
          pc_q <= pc_q + rel_off;
        end
        ccp_pkg::OP_REL_JUMP_ACC: begin
          pc_q <= pc_q + {{(ccp_pkg::PC_W-8){1'b0}}, acc_q};
        end
        ccp_pkg::OP_SUB_ENTER, ccp_pkg::OP_ABS_JUMP: begin
          pc_q <= {pc_q[ccp_pkg::PC_W-1:ccp_pkg::ABS_K_W],
                   ir_q[ccp_pkg::ABS_K_W-1:0]};
        end
        ccp_pkg::OP_SUB_ENTER_ACC: begin
          pc_q <= {pc_q[ccp_pkg::PC_W-1:8], acc_q};
        end
        ccp_pkg::OP_IRQ_EXIT, ccp_pkg::OP_SUB_EXIT, ccp_pkg::OP_SUB_EXIT_LIT: begin
          pc_q <= stk_top;
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // accumulator and status
  // ---------------------------------------------------------------
  logic [8:0] add_sum;
  logic [4:0] nib_sum;
  assign add_sum = {1'b0, acc_q} + {1'b0, ir_q[7:0]};
  assign nib_sum = {1'b0, acc_q[3:0]} + {1'b0, ir_q[3:0]};

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      acc_q <= ccp_pkg::ACC_RST;
    end else if (exec) begin
      case (op_q)
        ccp_pkg::OP_SUB_EXIT_LIT: acc_q <= ir_q[ccp_pkg::LIT_W-1:0];
        ccp_pkg::OP_PTR_LOAD:     acc_q <= mem_rdata_i;
        ccp_pkg::OP_IDX_LOAD:     acc_q <= mem_rdata_i;
        ccp_pkg::OP_AND_LIT:      acc_q <= and_res;
        ccp_pkg::OP_ADD_LIT:      acc_q <= add_sum[7:0];
        ccp_pkg::OP_AND_FILE: begin
          if (!ir_q[ccp_pkg::DEST_POS]) begin
            acc_q <= and_res;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      status_q <= ccp_pkg::STATUS_RST;
    end else if (exec) begin
      case (op_q)
        ccp_pkg::OP_STANDBY: begin
          status_q.watchdog_expiry_bit <= 1'b1;
          status_q.powerdown_bit       <= 1'b0;
        end
        ccp_pkg::OP_DOG_KICK: begin
          status_q.watchdog_expiry_bit <= 1'b1;
          status_q.powerdown_bit       <= 1'b1;
        end
        ccp_pkg::OP_PTR_LOAD, ccp_pkg::OP_IDX_LOAD: begin
          status_q.z <= (mem_rdata_i == 8'h00);
        end
        ccp_pkg::OP_AND_LIT, ccp_pkg::OP_AND_FILE: begin
          status_q.z <= (and_res == 8'h00);
        end
        ccp_pkg::OP_ADD_LIT: begin
          status_q.c  <= add_sum[8];
          status_q.nibble_out_bit <= nib_sum[4];
          status_q.z  <= (add_sum[7:0] == 8'h00);
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      presc_q <= ccp_pkg::PRESC_RST;
      for (int i = 0; i < ccp_pkg::DIR_REGS; i++) begin
        dir_q[i] <= ccp_pkg::DIR_RST;
      end
    end else if (exec) begin
      if (op_q == ccp_pkg::OP_LOAD_PRESC) begin
        presc_q <= acc_q;
      end
      if (op_q == ccp_pkg::OP_LOAD_DIR) begin
        dir_q[ir_q[ccp_pkg::DIR_SEL_W-1:0]] <= acc_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // one-cycle event pulses
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      standby_q      <= 1'b0;
      dog_kick_q     <= 1'b0;
      soft_restart_q <= 1'b0;
      irq_exit_q     <= 1'b0;
    end else begin
      standby_q      <= exec && (op_q == ccp_pkg::OP_STANDBY);
      dog_kick_q     <= exec && (op_q == ccp_pkg::OP_DOG_KICK);
      soft_restart_q <= exec && (op_q == ccp_pkg::OP_SOFT_RESTART);
      irq_exit_q     <= exec && (op_q == ccp_pkg::OP_IRQ_EXIT);
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign instr_ready_o  = (state_q == ST_FETCH);
  assign pc_o           = pc_q;
  assign mem_req_o      = mem_q;
  assign acc_o          = acc_q;
  assign status_o       = status_q;
  assign ptr0_o         = ptr0_q;
  assign ptr1_o         = ptr1_q;
  assign presc_cfg_o    = presc_q;
  assign dir_reg_o      = dir_q;
  assign standby_o      = standby_q;
  assign dog_kick_o     = dog_kick_q;
  assign soft_restart_o = soft_restart_q;
  assign irq_exit_o     = irq_exit_q;

endmodule
`default_nettype wire

// [sim/ccp_core_assertions.sv]
// port assertions for the instruction core
`timescale 1ns/100ps
`default_nettype none
module ccp_chk (
  input wire logic            ref_clk_i,
  input wire logic            nrst_i,
  input wire logic            instr_valid_i,
  input wire logic [13:0]     instr_i,
  input wire logic            instr_ready_o,
  input wire logic [14:0]     pc_o,
  input wire logic [7:0]      acc_o,
  input wire ccp_pkg::ccp_status_t status_o,
  input wire logic [15:0]     ptr0_o,
  input wire logic [15:0]     ptr1_o,
  input wire ccp_pkg::ccp_mem_req_t mem_req_o,
  input wire logic [7:0]      presc_cfg_o,
  input wire logic [7:0][7:0] dir_reg_o,
  input wire logic            standby_o,
  input wire logic            dog_kick_o,
  input wire logic            soft_restart_o,
  input wire logic            irq_exit_o
);
  // ------------------------------
  // operand capture and properties
  // ------------------------------
  logic [10:0] k_q;
  logic        take;
  assign take = instr_ready_o && instr_valid_i;
  always_ff @(posedge ref_clk_i) if (take) k_q <= instr_i[10:0];
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_one; !instr_ready_o ##1 instr_ready_o; endsequence
  sequence s_two; !instr_ready_o [*3] ##1 instr_ready_o; endsequence
  AST_ONE_CYC: assert property (take && instr_i[13:8] == 6'h39 |=> s_one)
    else $error("and literal cycle count");
  AST_TWO_CYC: assert property (take && instr_i[13:11] == 3'h5 |=> s_two)
    else $error("jump cycle count");
  AST_JMP_PC: assert property (take && instr_i[13:11] == 3'h5 |=> ##1 pc_o[10:0] == k_q)
    else $error("jump target");
  AST_AND: assert property (take && instr_i[13:8] == 6'h39 |=> ##1
    acc_o == ($past(acc_o) & k_q[7:0]) && status_o.z == (acc_o == 8'h00)) else $error("and result");
  AST_ADD: assert property (take && instr_i[13:8] == 6'h3E |=> ##1
    {status_o.c, acc_o} == 9'($past(acc_o)) + 9'(k_q[7:0])) else $error("add result");
  AST_PADD: assert property (take && instr_i[13:6] == 8'hC4 |=> (ptr0_o == $past(ptr0_o) +
    {{10{k_q[5]}}, k_q[5:0]} && $stable(status_o)) ##1 $stable(status_o)) else $error("pointer add");
  AST_DOG: assert property (take && instr_i == 14'h0064 |=> ##1 dog_kick_o &&
    status_o.watchdog_expiry_bit && status_o.powerdown_bit) else $error("watchdog kick");
  AST_STBY: assert property (take && instr_i == 14'h0063 |=> ##1 standby_o &&
    status_o.watchdog_expiry_bit && !status_o.powerdown_bit) else $error("standby entry");
  AST_DIR: assert property (take && instr_i[13:3] == 11'h00C && (instr_i[2:0] < 3'h2 || instr_i[2:0] > 3'h4)
    |=> ##1 dir_reg_o[k_q[2:0]] == $past(acc_o)) else $error("direction load");
  AST_PRESC: assert property (take && instr_i == 14'h0062 |=> ##1 presc_cfg_o == $past(acc_o))
    else $error("prescaler load");
  AST_STORE: assert property (take && instr_i[13:2] == 12'h007 |=> (mem_req_o.wr &&
    mem_req_o.wdata == $past(acc_o) && mem_req_o.addr == (k_q[1] ? $past(ptr1_o) : ptr1_o))
    ##1 $stable(status_o)) else $error("indirect store");
  AST_XTRA: assert property (take && instr_i[13:2] == 12'h005 && ptr1_o[15] |=> s_two)
    else $error("high pointer extra cycle");
  AST_IRQX: assert property (take && instr_i == 14'h0009 |=> ##1 irq_exit_o)
    else $error("interrupt exit pulse");
  AST_SOFT: assert property (take && instr_i == 14'h0001 |=> ##1 soft_restart_o && $stable(status_o))
    else $error("soft restart");
endmodule
bind ccp_core ccp_chk chk_u (.*);
`default_nettype wire

// [sim/ccp_core_tb.sv]
// self-checking bench for the instruction core
`timescale 1ns/100ps
`default_nettype none
module ccp_core_tb;
  logic                  ref_clk_i = 1'b0, nrst_i = 1'b0, instr_valid_i = 1'b0;
  logic [13:0]           instr_i = 14'h0000;
  logic [7:0]            mem_rdata_i = 8'h00, acc_o, presc_cfg_o;
  logic [14:0]           pc_o;
  logic [15:0]           ptr0_o, ptr1_o;
  logic [7:0][7:0]       dir_reg_o;
  logic                  instr_ready_o, standby_o, dog_kick_o, soft_restart_o, irq_exit_o;
  ccp_pkg::ccp_status_t  status_o;
  ccp_pkg::ccp_mem_req_t mem_req_o;
  int                    miscompares = 0, n_tests = 0, seed = 82;
  ccp_core dut_u (.*);
  always #5 ref_clk_i = ~ref_clk_i;
  // ------------------
  // tasks
  // ------------------
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdy();
    for (int n = 0; n < 20 && instr_ready_o !== 1'b1; n++) @(negedge ref_clk_i);
  endtask
  task automatic op(input logic [13:0] w);
    rdy();
    instr_valid_i = 1'b1;
    instr_i = w;
    @(negedge ref_clk_i);
    instr_valid_i = 1'b0;
    rdy();
  endtask
  task automatic close_out();
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
  // ------------------
  // main sequence
  // ------------------
  initial begin
    logic [7:0]  a, k;
    logic [15:0] p, q;
    logic        cy, nc;
    a = 8'h00;
    p = 16'h0000;
    q = 16'h0000;
    repeat (6) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    chk("status", 16'(5'h18), 16'(status_o));
    for (int i = 0; i < 12; i++) begin
      k = (i == 0) ? 8'hFF : (i == 1) ? 8'h01 : 8'($random(seed));
      op({6'h3E, k});
      nc = 5'(a[3:0]) + 5'(k[3:0]) > 5'h0F;
      {cy, a} = {1'b0, a} + {1'b0, k};
      chk("add", {5'h00, nc, cy, a == 8'h00, a},
          {5'h00, status_o.nibble_out_bit, status_o.c, status_o.z, acc_o});
      k = (i == 1) ? 8'hFF : 8'($random(seed));
      op({6'h39, k});
      a = a & k;
      chk("and", {8'(a == 8'h00), a}, {8'(status_o.z), acc_o});
      if (i < 8 && i != 3 && i != 4) op(14'h0060 | 14'(i));
      if (i < 8 && (i < 2 || i > 4)) chk("dir", 16'(a), 16'(dir_reg_o[i]));
      if (i == 2) chk("presc", 16'(a), 16'(presc_cfg_o));
      op({3'h5, 11'($random(seed))});
      chk("jump", 16'(instr_i[10:0]), 16'(pc_o[10:0]));
      op({8'hC4, (i == 0) ? 6'h3F : 6'($random(seed))});
      p = p + 16'(signed'(instr_i[5:0]));
      chk("ptr add", p, ptr0_o);
      mem_rdata_i = (i == 3) ? 8'h00 : 8'($random(seed));
      op({12'h005, (i < 4) ? 2'(i) : 2'($random(seed))});
      q = instr_i[0] ? q - 16'h0001 : q + 16'h0001;
      a = mem_rdata_i;
      chk("load", {8'(a == 8'h00), a}, {8'(status_o.z), acc_o});
      chk("ptr mode", q, ptr1_o);
      op({12'h007, (i == 1) ? 2'h3 : 2'($random(seed))});
      q = instr_i[0] ? q - 16'h0001 : q + 16'h0001;
    end
    op(14'h0063);
    chk("standby", 16'h0002, {14'h0000, status_o.watchdog_expiry_bit, status_o.powerdown_bit});
    op(14'h0064);
    chk("kick", 16'h0003, {14'h0000, status_o.watchdog_expiry_bit, status_o.powerdown_bit});
    op(14'h0001);
    p = 16'(pc_o + 15'h0001);
    op({3'h4, 11'h2A5});
    op(14'h0009);
    chk("irq exit", p, 16'(pc_o));
    op({3'h4, 11'h0F0});
    op({6'h34, 8'h5A});
    chk("exit lit", 16'h005A, 16'(acc_o));
    p = 16'(15'(pc_o - 15'h000F));
    op({5'h19, 9'h1F0});
    chk("rel jump", p, 16'(pc_o));
    close_out();
  end
endmodule
`default_nettype wire
